// ===== epi_map.svh
// Register offsets, field positions, reset values and timing for the pin interrupt block.
// Assumes inclusion by bare name from the top module.
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH

// ==========================================================================
// Register offsets (index on the plain register port)
`define EPI_OFF_CPU_CONTROL_SENSE 3'h0
`define EPI_OFF_EXTENDED_CPU_CONTROL 3'h1
`define EPI_OFF_INTERRUPT_ENABLE_CONTROL 3'h2
`define EPI_OFF_INTERRUPT_FLAGS 3'h3
`define EPI_OFF_IRQ_STATUS 3'h4
`define EPI_OFF_IRQ_MASK 3'h5
`define EPI_OFF_CORE_CONTROL 3'h6
`define EPI_OFF_PIN_STATE 3'h7

// ==========================================================================
// Field positions
`define EPI_BIT_SENSE_ZERO_LO 0
`define EPI_BIT_SENSE_ZERO_HI 1
`define EPI_BIT_SENSE_ONE_LO 2
`define EPI_BIT_SENSE_ONE_HI 3
`define EPI_BIT_EDGE_SEL_TWO 0
`define EPI_BIT_SRC_ONE 7
`define EPI_BIT_SRC_ZERO 6
`define EPI_BIT_SRC_TWO 5
`define EPI_BIT_VEC_SELECT 1
`define EPI_BIT_VEC_UNLOCK 0
`define EPI_BIT_GLOBAL_EN 7

// ==========================================================================
// Reset values and masks
`define EPI_RST_BYTE 8'h00
`define EPI_ENABLE_WMASK 8'hE3
`define EPI_FLAG_MASK 8'hE0

// ==========================================================================
// Timing: unlock window for the vector table select, in cycles
`define EPI_VEC_UNLOCK_CYCLES 3'h4

`endif

// ===== epi_pkg.sv
// Types shared by the pin interrupt block.
// Assumes the register map header sits beside it.
package epi_pkg;
    // Sense encodings for inputs zero and one
    typedef enum logic [1:0] {
        EPI_SENSE_LOW = 2'h0,
        EPI_SENSE_ANY = 2'h1,
        EPI_SENSE_FALL = 2'h2,
        EPI_SENSE_RISE = 2'h3
    } epi_sense_e;

    // Dispatch sequencer states, one-hot
    typedef enum logic [2:0] {
        EPI_ST_IDLE = 3'b001,
        EPI_ST_REQ = 3'b010,
        EPI_ST_WAIT = 3'b100
    } epi_state_e;

    typedef logic [7:0] epi_byte_t;
endpackage

// ===== epi_top.sv
// Three external pin interrupt sources with sense control, flags and vector dispatch.
// Assumes pins synchronous to clk; a core takes vectors with a one-cycle ack.
//
// Functional notes
// - Input zero requests only with global enable and its own enable set.
// - Sense field zero: low level, any change, falling, rising edge.
// - Input zero is sampled before edge detection; one-clock pulses suffice.
// - Edge select bit picks falling (0) or rising (1) for input two.
// - Input two edges are captured, then raise the request.
// - Enable register: input one bit 7, zero bit 6, two bit 5.
// - Pin activity requests even when the pin is an output.
// - Each taken request dispatches to its own vector.
// - Edges on inputs one and zero set flags at bits 7 and 6.
// - Flag plus global and source enable jumps to the vector.
// - Flags clear on dispatch or on a written one; zero is ignored.
// - Level-sensed sources keep their flag cleared.
// - Any triggering event on input two sets its flag.
// - Level mode on input one requests while the pin stays low.
`timescale 1ns/10ps
`include "epi_map.svh"

module epi_top #(
    parameter int NUM_SRC = 3
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ext_irq_in_zero, // Pin for input zero
    input wire logic ext_irq_in_one, // Pin for input one
    input wire logic ext_irq_in_two_async, // Pin for input two
    input wire logic [2:0] reg_addr, // Register index
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output logic irq, // Level interrupt from status and mask
    output logic vec_req, // Dispatch request to the core
    output logic [1:0] vec_num, // Vector: 1 zero, 2 one, 3 two
    input wire logic vec_ack, // Core takes the vector
    output logic vec_table_sel // Vector table select bit
);

    // ======================================================================
    // Register state
    epi_pkg::epi_byte_t sense_q;
    epi_pkg::epi_byte_t ext_ctl_q;
    logic [2:0] src_en_q; // {one, zero, two}
    logic vec_sel_q;
    logic vec_unlock_q;
    logic [2:0] unlock_cnt_q;
    logic [2:0] flag_q; // {one, zero, two}
    logic [2:0] ev_sts_q;
    logic [2:0] ev_msk_q;
    logic global_en_q;
    epi_pkg::epi_state_e state_q;
    logic [1:0] sel_q;

    // Write decode, shared by every register but the pin state
    function automatic logic hit(input logic [2:0] a, input logic [2:0] off, input logic s);
        hit = s && (a == off);
    endfunction

    logic wr_sense, wr_ext, wr_en, wr_flag, wr_sts, wr_msk, wr_core;
    assign wr_sense = hit(reg_addr, `EPI_OFF_CPU_CONTROL_SENSE, reg_wr);
    assign wr_ext = hit(reg_addr, `EPI_OFF_EXTENDED_CPU_CONTROL, reg_wr);
    assign wr_en = hit(reg_addr, `EPI_OFF_INTERRUPT_ENABLE_CONTROL, reg_wr);
    assign wr_flag = hit(reg_addr, `EPI_OFF_INTERRUPT_FLAGS, reg_wr);
    assign wr_sts = hit(reg_addr, `EPI_OFF_IRQ_STATUS, reg_wr);
    assign wr_msk = hit(reg_addr, `EPI_OFF_IRQ_MASK, reg_wr);
    assign wr_core = hit(reg_addr, `EPI_OFF_CORE_CONTROL, reg_wr);

    // ======================================================================
    // Pin sampling for the synchronous inputs
    logic [1:0] pin_now;
    logic [1:0] smp_a_q;
    logic [1:0] smp_b_q;
    assign pin_now = {ext_irq_in_one, ext_irq_in_zero};

    // Two consecutive samples; pins already synchronous, so no extra stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            smp_a_q <= 2'h3;
            smp_b_q <= 2'h3;
        end else begin
            smp_a_q <= pin_now;
            smp_b_q <= smp_a_q;
        end
    end

    // Per-source sense decode, the same logic for inputs zero and one
    logic [1:0] sync_edge;
    logic [1:0] sync_low;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sense
            epi_pkg::epi_sense_e mode;
            assign mode = epi_pkg::epi_sense_e'(sense_q[2*gi+1 -: 2]);
            always_comb begin
                sync_edge[gi] = 1'b0;
                sync_low[gi] = 1'b0;
                case (mode)
                    epi_pkg::EPI_SENSE_LOW: sync_low[gi] = !smp_a_q[gi];
                    epi_pkg::EPI_SENSE_ANY: sync_edge[gi] = smp_a_q[gi] ^ smp_b_q[gi];
                    epi_pkg::EPI_SENSE_FALL: sync_edge[gi] = smp_b_q[gi] & !smp_a_q[gi];
                    epi_pkg::EPI_SENSE_RISE: sync_edge[gi] = !smp_b_q[gi] & smp_a_q[gi];
                    default: sync_edge[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ======================================================================
    // Input two edge capture; with one clock the capture is a clocked sample
    // that needs no mode other than edge, limitation: pulses under 10 ns may miss
    logic two_prev_q;
    logic two_edge;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            two_prev_q <= 1'b1;
        end else begin
            two_prev_q <= ext_irq_in_two_async;
        end
    end
    // Both choices need the pin to differ from its last sample, so changing the edge select alone raises no edge
    assign two_edge = ext_ctl_q[`EPI_BIT_EDGE_SEL_TWO] ?
        (!two_prev_q && ext_irq_in_two_async) :
        (two_prev_q && !ext_irq_in_two_async);

    logic [2:0] set_ev;
    assign set_ev = {sync_edge[1], sync_edge[0], two_edge};

    // ======================================================================
    // Control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sense_q <= `EPI_RST_BYTE;
            ext_ctl_q <= `EPI_RST_BYTE;
        end else begin
            if (wr_sense) begin
                sense_q <= reg_wdata;
            end
            if (wr_ext) begin
                ext_ctl_q <= reg_wdata;
            end
        end
    end

    // Enable register; bits 4 to 2 are not stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_en_q <= 3'h0;
        end else if (wr_en) begin
            src_en_q <= {reg_wdata[`EPI_BIT_SRC_ONE], reg_wdata[`EPI_BIT_SRC_ZERO],
                         reg_wdata[`EPI_BIT_SRC_TWO]};
        end
    end

    // Vector table select: unlock bit opens a short window, then self-clears
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vec_sel_q <= 1'b0;
            vec_unlock_q <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end else if (wr_en && reg_wdata[`EPI_BIT_VEC_UNLOCK]) begin
            vec_unlock_q <= 1'b1;
            unlock_cnt_q <= `EPI_VEC_UNLOCK_CYCLES;
        end else begin
            if (wr_en && vec_unlock_q) begin
                vec_sel_q <= reg_wdata[`EPI_BIT_VEC_SELECT];
                vec_unlock_q <= 1'b0;
            end else if (unlock_cnt_q == 3'h1) begin
                vec_unlock_q <= 1'b0;
            end
            if (unlock_cnt_q != 3'h0) begin
                unlock_cnt_q <= unlock_cnt_q - 3'h1;
            end
        end
    end

    // Global enable stands in for the core's status register bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            global_en_q <= 1'b0;
        end else if (wr_core) begin
            global_en_q <= reg_wdata[`EPI_BIT_GLOBAL_EN];
        end
    end

    // ======================================================================
    // Request flags: set wins over clear so no edge is lost
    logic [2:0] wr_clr;
    logic [2:0] ack_clr;
    logic [2:0] level_mode;
    assign wr_clr = wr_flag ? {reg_wdata[`EPI_BIT_SRC_ONE], reg_wdata[`EPI_BIT_SRC_ZERO],
                               reg_wdata[`EPI_BIT_SRC_TWO]} : 3'h0;
    // Vector number back to its flag position in {one, zero, two}
    // A shift trick here would pick the wrong source, so the map is spelled out
    function automatic logic [2:0] vec_to_flag(input logic [1:0] v);
        case (v)
            2'h1: vec_to_flag = 3'h2; // Input zero
            2'h2: vec_to_flag = 3'h4; // Input one
            2'h3: vec_to_flag = 3'h1; // Input two
            default: vec_to_flag = 3'h0; // Idle, nothing to clear
        endcase
    endfunction

    // Only the source that was just taken loses its flag
    assign ack_clr = (state_q == epi_pkg::EPI_ST_REQ && vec_ack) ?
        vec_to_flag(sel_q) : 3'h0;
    assign level_mode = {sense_q[3:2] == 2'h0, sense_q[1:0] == 2'h0, 1'b0};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_q <= 3'h0;
        end else begin
            flag_q <= ((flag_q & ~wr_clr & ~ack_clr) | set_ev) & ~level_mode;
        end
    end

    // ======================================================================
    // Pending sources and vector dispatch
    logic [2:0] pend;
    assign pend = (flag_q | {sync_low[1], sync_low[0], 1'b0}) & src_en_q
                  & {3{global_en_q}};

    // Sequencer: raise a vector, hold it until acknowledged, one idle gap
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= epi_pkg::EPI_ST_IDLE;
            sel_q <= 2'h0;
        end else begin
            case (state_q)
                epi_pkg::EPI_ST_IDLE: begin
                    if (pend[1]) begin // Input zero has top priority
                        sel_q <= 2'h1;
                        state_q <= epi_pkg::EPI_ST_REQ;
                    end else if (pend[2]) begin
                        sel_q <= 2'h2;
                        state_q <= epi_pkg::EPI_ST_REQ;
                    end else if (pend[0]) begin
                        sel_q <= 2'h3;
                        state_q <= epi_pkg::EPI_ST_REQ;
                    end
                end
                epi_pkg::EPI_ST_REQ: begin
                    if (vec_ack) begin
                        state_q <= epi_pkg::EPI_ST_WAIT;
                    end
                end
                epi_pkg::EPI_ST_WAIT: state_q <= epi_pkg::EPI_ST_IDLE;
                default: state_q <= epi_pkg::EPI_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vec_req <= 1'b0;
            vec_num <= 2'h0;
        end else begin
            vec_req <= (state_q == epi_pkg::EPI_ST_REQ) && !vec_ack;
            // Vector drops together with the offer, so no number stands while idle
            vec_num <= (state_q == epi_pkg::EPI_ST_REQ && !vec_ack) ? sel_q : 2'h0;
        end
    end

    assign vec_table_sel = vec_sel_q;

    // ======================================================================
    // Block status and mask for the level interrupt output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev_sts_q <= 3'h0;
            ev_msk_q <= 3'h0;
        end else begin
            ev_sts_q <= (ev_sts_q & ~(wr_sts ? reg_wdata[7:5] : 3'h0)) | set_ev;
            if (wr_msk) begin
                ev_msk_q <= reg_wdata[7:5];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((ev_sts_q & ~(wr_sts ? reg_wdata[7:5] : 3'h0)) | set_ev) & ev_msk_q);
        end
    end

    // ======================================================================
    // Read port: data stand in the cycle after the strobe only
    epi_pkg::epi_byte_t rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            `EPI_OFF_CPU_CONTROL_SENSE: rd_mux = sense_q;
            `EPI_OFF_EXTENDED_CPU_CONTROL: rd_mux = ext_ctl_q;
            `EPI_OFF_INTERRUPT_ENABLE_CONTROL:
                rd_mux = {src_en_q, 3'h0, vec_sel_q, vec_unlock_q};
            `EPI_OFF_INTERRUPT_FLAGS: rd_mux = {flag_q, 5'h00};
            `EPI_OFF_IRQ_STATUS: rd_mux = {ev_sts_q, 5'h00};
            `EPI_OFF_IRQ_MASK: rd_mux = {ev_msk_q, 5'h00};
            `EPI_OFF_CORE_CONTROL: rd_mux = {global_en_q, 7'h00};
            `EPI_OFF_PIN_STATE: rd_mux = {smp_a_q[1], smp_a_q[0], two_prev_q, 5'h00};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule

// ===== epi_checker.sv
// Port checker for the pin interrupt block: register reads and vector offers.
// Assumes it is bound to epi_top and sees only its ports.
`timescale 1ns/10ps
module epi_checker (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic [2:0] reg_addr, // Register index
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic vec_req, // Vector offer
    input wire logic [1:0] vec_num, // Offered vector
    input wire logic vec_ack // Core take
);
    // ==========================================
    // One domain, so one clock and reset for all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_en_rsvd;
        reg_rd && reg_addr == 3'h2 |=> reg_rdata[4:2] == 3'h0;
    endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("enable spare bits set");
    property p_flag_rsvd;
        reg_rd && reg_addr == 3'h3 |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag spare bits set");
    property p_st_rsvd;
        reg_rd && reg_addr == 3'h4 |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_st_rsvd: assert property (p_st_rsvd) else $error("status spare bits set");
    property p_vec_valid;
        vec_req |-> vec_num != 2'h0;
    endproperty
    a_vec_valid: assert property (p_vec_valid) else $error("offer without vector");
    property p_vec_idle;
        !vec_req |-> vec_num == 2'h0;
    endproperty
    a_vec_idle: assert property (p_vec_idle) else $error("vector while idle");
    property p_vec_hold;
        vec_req && !vec_ack |=> vec_req && $stable(vec_num);
    endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("offer dropped early");
    property p_ack_drop;
        vec_req && vec_ack |=> !vec_req [*2];
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("offer kept after take");
    c_vec_zero: cover property (vec_req && vec_ack && vec_num == 2'h1);
    c_vec_one: cover property (vec_req && vec_ack && vec_num == 2'h2);
    c_vec_two: cover property (vec_req && vec_ack && vec_num == 2'h3);
endmodule

bind epi_top epi_checker chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vec_req(vec_req), .vec_num(vec_num), .vec_ack(vec_ack));

// ===== epi_core_model.sv
// Core stand-in: takes each offered vector after ack_delay cycles.
// Assumes one clock shared with the interrupt block.
`timescale 1ns/10ps
module epi_core_model (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic vec_req, // Offer
    input wire logic [1:0] vec_num, // Offered vector
    input wire logic [3:0] ack_delay, // Wait before take
    output logic vec_ack, // Take pulse
    output logic [1:0] last_vec, // Last vector taken
    output logic [7:0] taken_cnt // Takes so far
);
    logic [3:0] wait_q;
    // ==========================================
    // One take per offer; a slow core lets the offer stand
    always_ff @(posedge clk) begin
        vec_ack <= 1'b0;
        wait_q <= (vec_req && !vec_ack) ? wait_q + 4'h1 : 4'h0;
        if (!rst_n) begin
            taken_cnt <= 8'h00;
        end else if (vec_req && !vec_ack && wait_q == ack_delay) begin
            vec_ack <= 1'b1;
            last_vec <= vec_num;
            taken_cnt <= taken_cnt + 8'h01;
        end
    end
endmodule

// ===== test_external_pin_interrupts.sv
// Self-checking bench for the pin interrupt block.
// Assumes epi_top, the core model and the checker bind compile first.
`timescale 1ns/10ps
module test_external_pin_interrupts;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] pins = 3'h7;
    logic [2:0] addr = 3'h0;
    logic [7:0] wd = 8'h00;
    logic [3:0] dly = 4'h0;
    logic [7:0] rdata, tcnt;
    logic [1:0] vnum, lvec;
    logic irq, vreq, vack, vsel;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    epi_top dut (.clk(clk), .rst_n(rst_n), .ext_irq_in_zero(pins[0]), .ext_irq_in_one(pins[1]),
        .ext_irq_in_two_async(pins[2]), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .irq(irq), .vec_req(vreq), .vec_num(vnum),
        .vec_ack(vack), .vec_table_sel(vsel));
    epi_core_model core (.clk(clk), .rst_n(rst_n), .vec_req(vreq), .vec_num(vnum),
        .ack_delay(dly), .vec_ack(vack), .last_vec(lvec), .taken_cnt(tcnt));
    // ==========================================
    // Clock and hang guard, well above the run length
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobes get an idle edge after them, so no signal is set twice in a step
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp(rdata, exp);
        @(posedge clk);
    endtask
    // ==========================================
    // Every sense code on inputs zero and one, fall then rise
    task automatic t_sense();
        logic [7:0] fb;
        for (int s = 0; s < 2; s++) begin
            fb = (s == 0) ? 8'h40 : 8'h80;
            for (int m = 0; m < 4; m++) begin
                wr_reg(3'h0, 8'(m << (2 * s)));
                wr_reg(3'h3, 8'hE0);
                pins[s] <= 1'b0;
                repeat (3) @(posedge clk);
                chk_reg(3'h3, (m == 1 || m == 2) ? fb : 8'h00);
                wr_reg(3'h3, 8'hE0);
                pins[s] <= 1'b1;
                repeat (3) @(posedge clk);
                chk_reg(3'h3, (m == 1 || m == 3) ? fb : 8'h00);
            end
        end
    endtask
    // Reset values, spare bits, then both edge choices on input two
    task automatic t_two();
        chk_reg(3'h1, 8'h00);
        wr_reg(3'h2, 8'hFC);
        chk_reg(3'h2, 8'hE0);
        cmp({7'h00, vsel}, 8'h00);
        wr_reg(3'h2, 8'h01);
        wr_reg(3'h2, 8'h02);
        chk_reg(3'h2, 8'h02);
        cmp({7'h00, vsel}, 8'h01);
        wr_reg(3'h2, 8'h00);
        for (int e = 0; e < 2; e++) begin
            wr_reg(3'h1, 8'(e));
            wr_reg(3'h3, 8'h20);
            pins[2] <= 1'b0;
            repeat (3) @(posedge clk);
            chk_reg(3'h3, e ? 8'h00 : 8'h20);
            wr_reg(3'h3, 8'h00);
            chk_reg(3'h3, e ? 8'h00 : 8'h20);
            wr_reg(3'h3, 8'h20);
            pins[2] <= 1'b1;
            repeat (3) @(posedge clk);
            chk_reg(3'h3, e ? 8'h20 : 8'h00);
            wr_reg(3'h3, 8'h20);
        end
    endtask
    // Gating held off by the global enable, then each vector, prompt to slow
    task automatic t_disp();
        wr_reg(3'h0, 8'h0A);
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h3, 8'hE0);
        wr_reg(3'h2, 8'hE0);
        pins[0] <= 1'b0;
        repeat (8) @(posedge clk);
        cmp(tcnt, 8'h00);
        chk_reg(3'h3, 8'h40);
        for (int s = 0; s < 3; s++) begin
            dly <= 4'(s * 4);
            if (s == 0) wr_reg(3'h6, 8'h80);
            else pins[s] <= 1'b0;
            for (int i = 0; i < 40 && tcnt !== 8'(s + 1); i++) @(posedge clk);
            cmp(tcnt, 8'(s + 1));
            cmp({6'h00, lvec}, 8'(s + 1));
            chk_reg(3'h3, 8'h00);
        end
        pins <= 3'h7;
        repeat (4) @(posedge clk);
    endtask
    // Input one in level mode requests again and again while held low
    task automatic t_level();
        logic [7:0] c;
        dly <= 4'h2;
        wr_reg(3'h0, 8'h02);
        pins[1] <= 1'b0;
        repeat (24) @(posedge clk);
        pins[1] <= 1'b1;
        repeat (6) @(posedge clk);
        c = tcnt;
        cmp({7'h00, c > 8'h04}, 8'h01);
        chk_reg(3'h3, 8'h00);
        repeat (10) @(posedge clk);
        cmp(tcnt, c);
    endtask
    // Interrupt line: event held off by the mask, unmasked, cleared
    task automatic t_irq();
        wr_reg(3'h6, 8'h00);
        wr_reg(3'h5, 8'h00);
        wr_reg(3'h4, 8'hE0);
        pins[0] <= 1'b0;
        repeat (4) @(posedge clk);
        cmp({7'h00, irq}, 8'h00);
        chk_reg(3'h4, 8'h40);
        wr_reg(3'h5, 8'h40);
        @(posedge clk);
        cmp({7'h00, irq}, 8'h01);
        wr_reg(3'h4, 8'h40);
        @(posedge clk);
        cmp({7'h00, irq}, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_two();
        t_sense();
        t_disp();
        t_level();
        t_irq();
        stop_test();
    end
endmodule
